/* File: src/pzs_pkg.sv */
// Purpose: shared constants and types for the pad zero-suppress readout
// Assumes: one 125 MHz clock, asynchronous active-high reset
// Notes: Operation list below
// Operation
// - subtract pedestal, then suppress at or below threshold
// - read 1, 3, 4 or 8 groups of 16
// - four-line readout protocol
// - event data store 512 by 19
// - hit bitmap store 256 by 16
// - pedestal and threshold store 256 by 16
// - one 19-bit shared bus, one driver
// - writes at most 15 MHz, reads 20 MHz
// - channel count and sample width configurable
// - one clock per pedestal entry access
// - collector reads back and reloads pedestals
// - only passing samples and the end-of-event word enter the fifo
// - drain starts only after 6.4 us
// - end-of-event word closes, collector drops it
// - test mode injects samples over the bus
// - collector stores 512 by 32, 32-bit link
// - collector serves one processor, up to 128 channels
// - reset aborts readout, forces defined state
package pzs_pkg;
    localparam int CLK_MHZ       = 125;
    localparam int WRITE_SEQ_NS  = 6400;
    localparam int WRITE_SEQ_CYC = WRITE_SEQ_NS * CLK_MHZ / 1000;
    localparam int READ_MAX_MHZ  = 20;
    localparam int WRITE_MAX_MHZ = 15;
    localparam int READ_GAP_CYC  = (CLK_MHZ + READ_MAX_MHZ - 1) / READ_MAX_MHZ;
    localparam int WRITE_GAP_CYC = (CLK_MHZ + WRITE_MAX_MHZ - 1)
                                   / WRITE_MAX_MHZ;
    localparam int TMR_W         = 10;
    localparam int GAP_W         = 4;

    localparam int BUS_W         = 19;
    localparam int CMD_W         = 3;
    localparam int SMP_W         = 12;
    localparam int CH_W          = 7;
    localparam int GRP_BITS      = 4;
    localparam int EVT_W         = 5;
    localparam int DATA_DEPTH    = 512;
    localparam int DPTR_W        = 9;
    localparam int MAP_DEPTH     = 256;
    localparam int MAP_W         = 16;
    localparam int PED_DEPTH     = 256;
    localparam int PED_W         = 16;
    localparam int PTR_W         = 8;
    localparam int PED_LSB       = 0;
    localparam int PED_MSB       = 11;
    localparam int THR_LSB       = 12;
    localparam int THR_MSB       = 15;
    localparam int MODE_TEST_BIT = 0;
    localparam int MODE_GRP_LSB  = 1;
    localparam int MODE_W        = 3;

    localparam logic [BUS_W-1:0] EOE_WORD = 19'h7f000;
    localparam logic [BUS_W-1:0] BUS_IDLE = 19'h7ffff;

    localparam logic [1:0] GRP_SEL_1 = 2'h0;
    localparam logic [1:0] GRP_SEL_3 = 2'h1;
    localparam logic [1:0] GRP_SEL_4 = 2'h2;
    localparam logic [7:0] NCH_G1    = 8'h10;
    localparam logic [7:0] NCH_G3    = 8'h30;
    localparam logic [7:0] NCH_G4    = 8'h40;
    localparam logic [7:0] NCH_G8    = 8'h80;

    localparam int COL_DEPTH     = 512;
    localparam int COL_AW        = 9;
    localparam int LINK_W        = 32;
    localparam int APB_AW        = 12;
    localparam logic [APB_AW-1:0] REG_CTRL   = 12'h000;
    localparam logic [APB_AW-1:0] REG_CMD    = 12'h004;
    localparam logic [APB_AW-1:0] REG_RESULT = 12'h008;
    localparam logic [APB_AW-1:0] REG_STAT   = 12'h00c;
    localparam int CMD_LSB       = 19;

    typedef enum logic [2:0] {
        CMD_NOP      = 3'b000,
        CMD_RD_DATA  = 3'b001,
        CMD_WR_PED   = 3'b010,
        CMD_RD_PED   = 3'b011,
        CMD_RD_MAP   = 3'b100,
        CMD_SET_PTR  = 3'b101,
        CMD_INJECT   = 3'b110,
        CMD_SET_MODE = 3'b111
    } pzs_cmd_t;

    function automatic logic [7:0] pzs_chans(input logic [1:0] code);
        logic [7:0] n;
        n = NCH_G8;
        if (code == GRP_SEL_1)
            n = NCH_G1;
        else if (code == GRP_SEL_3)
            n = NCH_G3;
        else if (code == GRP_SEL_4)
            n = NCH_G4;
        return n;
    endfunction
endpackage

/* File: src/pzs_link_if.sv */
// Purpose: link between processor and column collector
// Assumes: both ends on the same clock
// Notes: shared bus level resolved here from the active-low enables
`timescale 1ns/1ns
interface pzs_link_if;
    import pzs_pkg::*;
    logic [CMD_W-1:0] cmd;
    logic             strb;
    logic [BUS_W-1:0] dev_bus_o;
    logic             dev_oe_n;
    logic [BUS_W-1:0] col_bus_o;
    logic             col_oe_n;
    logic [BUS_W-1:0] bus;

    // undriven bus floats to the pulled-up idle level
    assign bus = !dev_oe_n ? dev_bus_o : (!col_oe_n ? col_bus_o : BUS_IDLE);

    modport dev (input cmd, input strb, input bus,
                 output dev_bus_o, output dev_oe_n);
    modport col (output cmd, output strb, output col_bus_o,
                 output col_oe_n, input bus);
endinterface

/* File: src/pzs_processor.sv */
// Purpose: per-channel pedestal subtraction and zero suppression
// Assumes: samples arrive with SAMPLE_VLD_I in channel order after TRIG_I
// Notes: link commands answered one cycle after the strobe
`timescale 1ns/1ns
module pzs_processor
    import pzs_pkg::*;
(
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_I,
    input  wire logic             TRIG_I,
    input  wire logic             SAMPLE_VLD_I,
    input  wire logic [SMP_W-1:0] SAMPLE_I,
    output logic                  BUSY_O,
    output logic                  EVT_DONE_O,
    output logic                  TEST_MODE_O,
    pzs_link_if.dev               lnk
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ  = 2'b01,
        ST_EOE  = 2'b10
    } pzs_st_t;

    pzs_st_t          state_r;
    logic [CH_W-1:0]  ch_r;
    logic [TMR_W-1:0] tmr_r;
    logic [EVT_W-1:0] evt_r;
    logic [MAP_W-1:0] hit_r;
    logic [1:0]       grp_sel_r;
    logic [PTR_W-1:0] ptr_r;
    logic [PED_W-1:0] ped_mem [PED_DEPTH];
    logic [MAP_W-1:0] map_mem [MAP_DEPTH];
    logic [BUS_W-1:0] data_mem [DATA_DEPTH];
    logic [DPTR_W-1:0] wptr_r;
    logic [DPTR_W-1:0] rptr_r;
    logic [DPTR_W:0]  cnt_r;
    logic [BUS_W-1:0] bus_o_r;
    logic             oe_n_r;

    pzs_cmd_t         cmd;
    logic [7:0]       nch;
    logic             smp_vld;
    logic [CH_W-1:0]  smp_ch;
    logic [SMP_W-1:0] smp_val;
    logic [PED_W-1:0] ped_ent;
    logic [SMP_W-1:0] ped_val;
    logic [SMP_W-1:0] thr_val;
    logic [SMP_W-1:0] diff;
    logic             keep;
    logic             last_ch;
    logic             grp_end;
    logic             end_acq;
    logic             rd_pop;
    logic             wr_ok;
    logic             eoe_wr;
    logic             push;
    logic [BUS_W-1:0] push_word;
    logic [MAP_W-1:0] hit_bit;

    assign cmd = pzs_cmd_t'(lnk.cmd);
    assign nch = pzs_chans(grp_sel_r);

    // injected samples replace the adc path
    assign smp_vld = TEST_MODE_O
                   ? (lnk.strb && cmd == CMD_INJECT && state_r == ST_ACQ)
                   : (SAMPLE_VLD_I && state_r == ST_ACQ);
    assign smp_ch  = TEST_MODE_O ? lnk.bus[BUS_W-1 -: CH_W] : ch_r;
    assign smp_val = TEST_MODE_O ? lnk.bus[SMP_W-1:0] : SAMPLE_I;

    assign ped_ent = ped_mem[PTR_W'(smp_ch)];
    assign ped_val = ped_ent[PED_MSB:PED_LSB];
    assign thr_val = SMP_W'(ped_ent[THR_MSB:THR_LSB]);

    assign diff = (smp_val > ped_val) ? smp_val - ped_val : '0;
    assign keep = smp_vld && (diff > thr_val);

    assign last_ch = smp_ch == CH_W'(nch - 8'h01);
    assign grp_end = smp_vld
                  && (smp_ch[GRP_BITS-1:0] == GRP_BITS'(MAP_W - 1) || last_ch);
    assign hit_bit = keep ? (MAP_W'(1) << smp_ch[GRP_BITS-1:0]) : '0;

    // write window closes after 6.4 us
    assign end_acq = state_r == ST_ACQ
                  && ((smp_vld && last_ch)
                      || tmr_r == TMR_W'(WRITE_SEQ_CYC - 1));

    assign rd_pop = lnk.strb && cmd == CMD_RD_DATA && cnt_r != '0;
    // one slot always kept free so the closing word still fits
    assign wr_ok  = keep && cnt_r < (DPTR_W + 1)'(DATA_DEPTH - 1);
    assign eoe_wr = state_r == ST_EOE && cnt_r < (DPTR_W + 1)'(DATA_DEPTH);
    assign push   = wr_ok || eoe_wr;
    assign push_word = eoe_wr ? EOE_WORD : {smp_ch, diff};

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_r    <= ST_IDLE;
            ch_r       <= '0;
            tmr_r      <= '0;
            evt_r      <= '0;
            BUSY_O     <= 1'b0;
            EVT_DONE_O <= 1'b0;
        end
        else
        begin
            EVT_DONE_O <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (TRIG_I)
                    begin
                        state_r <= ST_ACQ;
                        ch_r    <= '0;
                        tmr_r   <= '0;
                        BUSY_O  <= 1'b1;
                    end
                end
                ST_ACQ:
                begin
                    tmr_r <= tmr_r + TMR_W'(1);
                    if (smp_vld)
                        ch_r <= ch_r + CH_W'(1);
                    if (end_acq)
                        state_r <= ST_EOE;
                end
                ST_EOE:
                begin
                    state_r    <= ST_IDLE;
                    evt_r      <= evt_r + EVT_W'(1);
                    BUSY_O     <= 1'b0;
                    EVT_DONE_O <= 1'b1;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // hit bitmap per group and event
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            hit_r <= '0;
            for (int i = 0; i < MAP_DEPTH; i++)
                map_mem[i] <= '0;
        end
        else if (state_r == ST_IDLE && TRIG_I)
            hit_r <= '0;
        else if (grp_end)
        begin
            map_mem[{evt_r, smp_ch[CH_W-1 -: 3]}] <= hit_r | hit_bit;
            hit_r <= '0;
        end
        else if (smp_vld)
            hit_r <= hit_r | hit_bit;
    end

    // only kept words and the closing word enter the fifo
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end
        else
        begin
            if (push)
                wptr_r <= wptr_r + DPTR_W'(1);
            if (rd_pop)
                rptr_r <= rptr_r + DPTR_W'(1);
            if (push && !rd_pop)
                cnt_r <= cnt_r + (DPTR_W + 1)'(1);
            else if (rd_pop && !push)
                cnt_r <= cnt_r - (DPTR_W + 1)'(1);
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (push)
            data_mem[wptr_r] <= push_word;
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < PED_DEPTH; i++)
                ped_mem[i] <= '0;
        end
        else if (lnk.strb && cmd == CMD_WR_PED)
            ped_mem[ptr_r] <= lnk.bus[PED_W-1:0];
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ptr_r <= '0;
        else if (lnk.strb && cmd == CMD_SET_PTR)
            ptr_r <= lnk.bus[PTR_W-1:0];
        else if (lnk.strb && (cmd == CMD_WR_PED || cmd == CMD_RD_PED
                              || cmd == CMD_RD_MAP))
            ptr_r <= ptr_r + PTR_W'(1);
    end

    // mode changes mid-event take effect on the next sample
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            TEST_MODE_O <= 1'b0;
            grp_sel_r   <= GRP_SEL_3;
        end
        else if (lnk.strb && cmd == CMD_SET_MODE)
        begin
            TEST_MODE_O <= lnk.bus[MODE_TEST_BIT];
            grp_sel_r   <= lnk.bus[MODE_GRP_LSB +: 2];
        end
    end

    // reply to the four protocol lines
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bus_o_r <= BUS_IDLE;
            oe_n_r  <= 1'b1;
        end
        else
        begin
            // drive only in the reply cycle
            oe_n_r <= 1'b1;
            if (lnk.strb)
            begin
                case (cmd)
                    CMD_RD_DATA:
                    begin
                        bus_o_r <= (cnt_r != '0) ? data_mem[rptr_r] : EOE_WORD;
                        oe_n_r  <= 1'b0;
                    end
                    CMD_RD_PED:
                    begin
                        bus_o_r <= BUS_W'(ped_mem[ptr_r]);
                        oe_n_r  <= 1'b0;
                    end
                    CMD_RD_MAP:
                    begin
                        bus_o_r <= BUS_W'(map_mem[ptr_r]);
                        oe_n_r  <= 1'b0;
                    end
                    default:
                        oe_n_r <= 1'b1;
                endcase
            end
        end
    end

    assign lnk.dev_bus_o = bus_o_r;
    assign lnk.dev_oe_n  = oe_n_r;
endmodule

/* File: src/pzs_collector.sv */
// Purpose: column collector: drains the processor, stores, forwards
// Assumes: APB slave with no wait states, same clock as the link
// Notes: one software command may be pending at a time
`timescale 1ns/1ns
module pzs_collector
    import pzs_pkg::*;
(
    input  wire logic              REF_CLK_I,
    input  wire logic              RST_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [APB_AW-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              TRIG_I,
    output logic      [LINK_W-1:0] LINK_DATA_O,
    output logic                   LINK_VLD_O,
    pzs_link_if.col                lnk
);
    typedef enum logic [1:0] {
        CS_IDLE  = 2'b00,
        CS_WAIT  = 2'b01,
        CS_DRAIN = 2'b10,
        CS_SEND  = 2'b11
    } pzs_cst_t;

    pzs_cst_t          cst_r;
    logic [TMR_W-1:0]  wait_r;
    logic [GAP_W-1:0]  gap_r;
    logic              strb_r;
    pzs_cmd_t          cmd_r;
    logic [BUS_W-1:0]  cbus_r;
    logic              coe_n_r;
    logic              cap_r;
    logic              pend_r;
    pzs_cmd_t          pcmd_r;
    logic [BUS_W-1:0]  pdat_r;
    logic [MODE_W-1:0] ctrl_r;
    logic [BUS_W-1:0]  result_r;
    logic [LINK_W-1:0] mem [COL_DEPTH];
    logic [COL_AW:0]   wcnt_r;
    logic [COL_AW:0]   sidx_r;

    logic setup;
    logic wr_acc;
    logic issue_sw;
    logic issue_dr;
    logic sw_rd;
    logic got_eoe;
    logic store;

    assign setup    = PSEL_I && !PENABLE_I;
    assign wr_acc   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    // writes may also go out while waiting, so injected samples reach
    // a running event; reads stay in idle to keep replies out of the drain
    assign issue_sw = gap_r == '0 && pend_r
                   && (cst_r == CS_IDLE || (cst_r == CS_WAIT && !sw_rd));
    // one read in flight until the closing word
    assign issue_dr = gap_r == '0 && cst_r == CS_DRAIN && !strb_r && !cap_r;
    assign sw_rd    = pcmd_r == CMD_RD_DATA || pcmd_r == CMD_RD_PED
                   || pcmd_r == CMD_RD_MAP;
    assign got_eoe  = cap_r && cst_r == CS_DRAIN && lnk.bus == EOE_WORD;
    assign store    = cap_r && cst_r == CS_DRAIN && !got_eoe
                   && wcnt_r < (COL_AW + 1)'(COL_DEPTH);

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= '0;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O  <= setup;
            PSLVERR_O <= 1'b0;
            if (!setup)
                PRDATA_O <= '0;
            else if (PADDR_I == REG_CTRL)
                PRDATA_O <= 32'(ctrl_r);
            else if (PADDR_I == REG_CMD)
                PRDATA_O <= 32'({pcmd_r, pdat_r});
            else if (PADDR_I == REG_RESULT)
                PRDATA_O <= 32'(result_r);
            else if (PADDR_I == REG_STAT)
                PRDATA_O <= 32'({wcnt_r, cst_r, pend_r});
            else
            begin
                PRDATA_O  <= '0;
                PSLVERR_O <= 1'b1;
            end
        end
    end

    // a write while a command is pending is dropped
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pend_r <= 1'b0;
            pcmd_r <= CMD_NOP;
            pdat_r <= '0;
            ctrl_r <= '0;
        end
        else if (issue_sw)
            pend_r <= 1'b0;
        else if (wr_acc && !pend_r && PADDR_I == REG_CTRL)
        begin
            ctrl_r <= PWDATA_I[MODE_W-1:0];
            pcmd_r <= CMD_SET_MODE;
            pdat_r <= BUS_W'(PWDATA_I[MODE_W-1:0]);
            pend_r <= 1'b1;
        end
        else if (wr_acc && !pend_r && PADDR_I == REG_CMD)
        begin
            pcmd_r <= pzs_cmd_t'(PWDATA_I[CMD_LSB +: CMD_W]);
            pdat_r <= PWDATA_I[BUS_W-1:0];
            pend_r <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            gap_r   <= '0;
            strb_r  <= 1'b0;
            cmd_r   <= CMD_NOP;
            cbus_r  <= BUS_IDLE;
            coe_n_r <= 1'b1;
            cap_r   <= 1'b0;
        end
        else
        begin
            strb_r  <= 1'b0;
            coe_n_r <= 1'b1;
            cap_r   <= strb_r && (cmd_r == CMD_RD_DATA
                                  || cmd_r == CMD_RD_PED
                                  || cmd_r == CMD_RD_MAP);
            if (gap_r != '0)
                gap_r <= gap_r - GAP_W'(1);
            else if (issue_dr)
            begin
                // read strobes at most 20 MHz
                strb_r <= 1'b1;
                cmd_r  <= CMD_RD_DATA;
                gap_r  <= GAP_W'(READ_GAP_CYC - 1);
            end
            else if (issue_sw)
            begin
                strb_r <= 1'b1;
                cmd_r  <= pcmd_r;
                cbus_r <= pdat_r;
                // drive only in the strobe cycle
                coe_n_r <= sw_rd;
                // write strobes at most 15 MHz
                gap_r  <= sw_rd ? GAP_W'(READ_GAP_CYC - 1)
                                : GAP_W'(WRITE_GAP_CYC - 1);
            end
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (store)
            mem[wcnt_r[COL_AW-1:0]] <= LINK_W'(lnk.bus);
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cst_r       <= CS_IDLE;
            wait_r      <= '0;
            wcnt_r      <= '0;
            sidx_r      <= '0;
            result_r    <= '0;
            LINK_DATA_O <= '0;
            LINK_VLD_O  <= 1'b0;
        end
        else
        begin
            LINK_VLD_O <= 1'b0;
            if (cap_r && cst_r != CS_DRAIN)
                result_r <= lnk.bus;
            if (store)
                wcnt_r <= wcnt_r + (COL_AW + 1)'(1);
            case (cst_r)
                CS_IDLE:
                begin
                    if (TRIG_I)
                    begin
                        cst_r  <= CS_WAIT;
                        wait_r <= '0;
                        wcnt_r <= '0;
                    end
                end
                CS_WAIT:
                begin
                    // hold off until writing is over
                    wait_r <= wait_r + TMR_W'(1);
                    if (wait_r == TMR_W'(WRITE_SEQ_CYC - 1))
                        cst_r <= CS_DRAIN;
                end
                CS_DRAIN:
                begin
                    if (got_eoe)
                    begin
                        cst_r  <= CS_SEND;
                        sidx_r <= '0;
                    end
                end
                CS_SEND:
                begin
                    if (sidx_r == wcnt_r)
                        cst_r <= CS_IDLE;
                    else
                    begin
                        LINK_DATA_O <= mem[sidx_r[COL_AW-1:0]];
                        LINK_VLD_O  <= 1'b1;
                        sidx_r      <= sidx_r + (COL_AW + 1)'(1);
                    end
                end
                default:
                    cst_r <= CS_IDLE;
            endcase
        end
    end

    assign lnk.cmd       = cmd_r;
    assign lnk.strb      = strb_r;
    assign lnk.col_bus_o = cbus_r;
    assign lnk.col_oe_n  = coe_n_r;
endmodule

/* File: tb/pzs_link_chk.sv */
// Purpose: protocol checks on the processor-collector link
// Assumes: one clock, asynchronous active-high reset
// Notes: takes the link signals as plain inputs
`timescale 1ns/1ns
module pzs_link_chk
    import pzs_pkg::*;
(
    input wire logic             REF_CLK_I,
    input wire logic             RST_I,
    input wire logic [CMD_W-1:0] cmd,
    input wire logic             strb,
    input wire logic [BUS_W-1:0] dev_bus_o,
    input wire logic             dev_oe_n,
    input wire logic [BUS_W-1:0] col_bus_o,
    input wire logic             col_oe_n,
    input wire logic [BUS_W-1:0] bus
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    sequence rd_s;
        strb && cmd inside {CMD_RD_DATA, CMD_RD_PED, CMD_RD_MAP};
    endsequence
    sequence wr_s;
        strb && !(cmd inside {CMD_RD_DATA, CMD_RD_PED, CMD_RD_MAP});
    endsequence
    chk_one_driver: assert property
        (dev_oe_n || col_oe_n) else $error("both ends drive the bus");
    chk_read_reply: assert property
        (rd_s |=> !dev_oe_n ##1 dev_oe_n) else $error("reply not one cycle");
    chk_write_quiet: assert property
        (wr_s |=> dev_oe_n) else $error("reply to a write");
    chk_reply_cause: assert property
        (!dev_oe_n |-> $past(strb) && $past(cmd) != CMD_NOP
         && $past(cmd) inside {CMD_RD_DATA, CMD_RD_PED, CMD_RD_MAP})
        else $error("unrequested reply");
    chk_read_gap: assert property
        (rd_s |=> !strb [*6]) else $error("reads too close");
    chk_write_gap: assert property
        (wr_s |=> !strb [*8]) else $error("writes too close");
    chk_col_window: assert property
        (!col_oe_n |-> wr_s) else $error("collector drives off strobe");
    chk_idle_level: assert property
        (dev_oe_n && col_oe_n |-> bus == BUS_IDLE) else $error("bus idle");
    chk_kept_value: assert property
        ((strb && cmd == CMD_RD_DATA ##1 dev_bus_o != EOE_WORD)
         |-> dev_bus_o[11:0] != 12'h0) else $error("zero value kept");
endmodule

/* File: tb/tb.sv */
// Purpose: processor and collector joined by the link, driven over APB
// Assumes: 125 MHz clock, random samples, ch0 gets a pedestal
// Notes: link words compared against a queue of expected kept samples
`timescale 1ns/1ns
module tb;
    import pzs_pkg::*;
    logic              clk = 0, rst = 1, trig = 0, vld = 0, psel = 0;
    logic              pen = 0, pwr = 0, perr, prdy, busy, done, tmode;
    logic              lvld, lerr;
    logic [SMP_W-1:0]  smp = '0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0]       pwd = '0, prd, rd, ldat;
    logic [31:0]       q[$];
    int                n_mismatch = 0, num_checks = 0, seed = 86;
    pzs_link_if lnk();
    pzs_processor i_pzs_processor (.REF_CLK_I(clk), .RST_I(rst),
        .TRIG_I(trig), .SAMPLE_VLD_I(vld), .SAMPLE_I(smp), .BUSY_O(busy),
        .EVT_DONE_O(done), .TEST_MODE_O(tmode), .lnk(lnk.dev));
    pzs_collector i_pzs_collector (.REF_CLK_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .TRIG_I(trig), .LINK_DATA_O(ldat), .LINK_VLD_O(lvld), .lnk(lnk.col));
    pzs_link_chk i_pzs_link_chk (.REF_CLK_I(clk), .RST_I(rst),
        .cmd(lnk.cmd), .strb(lnk.strb), .dev_bus_o(lnk.dev_bus_o),
        .dev_oe_n(lnk.dev_oe_n), .col_bus_o(lnk.col_bus_o),
        .col_oe_n(lnk.col_oe_n), .bus(lnk.bus));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // closing word must never reach the link
    always @(posedge clk)
        if (lvld === 1'b1)
            chk(ldat, q.size() > 0 ? q.pop_front() : 32'hffffffff);
    task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        for (n = 50; n > 0 && prdy !== 1'b1; n--) @(posedge clk);
        chk(32'(n == 0), 32'h0);
        if (n == 0) stop_test();
        rd = prd;
        lerr = perr;
        psel <= 0;
        pen <= 0;
    endtask
    // a software order counts as done once the collector has issued it
    task automatic sw(input logic [APB_AW-1:0] a, input logic [31:0] d);
        int n;
        apb(1, a, d);
        rd = '1;
        for (n = 1000; n > 0 && rd[0] !== 1'b0; n--) apb(0, REG_STAT, 0);
        chk(32'(n == 0), 32'h0);
        if (n == 0) stop_test();
    endtask
    task automatic ev(input logic [1:0] code, input int nch);
        int i;
        int n;
        logic [11:0] s, v;
        sw(REG_CTRL, {29'h0, code, 1'b0});
        @(posedge clk);
        // trigger leads, samples follow in order
        trig <= 1;
        for (i = 0; i < nch; i++)
        begin
            s = 12'({$random(seed)} % 24);
            v = (i > 0) ? s : (s > 12'h10) ? s - 12'h10 : 12'h0;
            if (v > ((i > 0) ? 12'h0 : 12'h2))
                q.push_back({13'h0, 7'(i), v});
            @(posedge clk);
            trig <= 0;
            vld <= 1;
            smp <= s;
        end
        @(posedge clk);
        vld <= 0;
        for (n = 200; n > 0 && done !== 1'b1; n--) @(posedge clk);
        chk({31'h0, busy} | 32'(n == 0), 32'h0);
        if (n == 0) stop_test();
        for (n = 3000; n > 0 && q.size() > 0; n--) @(posedge clk);
        chk(32'(n == 0), 32'h0);
        if (n == 0) stop_test();
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 0;
        sw(REG_CMD, {10'h0, CMD_SET_PTR, 19'h0});
        sw(REG_CMD, {10'h0, CMD_WR_PED, 19'h2010});
        sw(REG_CMD, {10'h0, CMD_SET_PTR, 19'h0});
        sw(REG_CMD, {10'h0, CMD_RD_PED, 19'h0});
        apb(0, REG_RESULT, 0);
        chk(rd, 32'h2010);
        apb(0, 12'h010, 0);
        chk({31'h0, lerr}, 32'h1);
        sw(REG_CTRL, 32'h1);
        chk({31'h0, tmode}, 32'h1);
        // injected samples take the suppression path of one group
        @(posedge clk);
        trig <= 1;
        @(posedge clk);
        trig <= 0;
        q.push_back(32'h00005);
        sw(REG_CMD, {10'h0, CMD_INJECT, 7'h00, 12'h015});
        q.push_back(32'h0f001);
        sw(REG_CMD, {10'h0, CMD_INJECT, 7'h0f, 12'h001});
        for (int n = 3000; n > 0 && q.size() > 0; n--) @(posedge clk);
        chk(32'(q.size()), 32'h0);
        if (q.size() > 0) stop_test();
        sw(REG_CMD, {10'h0, CMD_SET_PTR, 19'h0});
        sw(REG_CMD, {10'h0, CMD_RD_MAP, 19'h0});
        apb(0, REG_RESULT, 0);
        chk(rd, 32'h8001);
        for (int c = 0; c < 4; c++)
            ev(2'(c), c == 0 ? 16 : c == 1 ? 48 : c == 2 ? 64 : 128);
        // abort mid-event: no word may appear afterwards
        @(posedge clk);
        trig <= 1;
        @(posedge clk);
        trig <= 0;
        @(posedge clk);
        chk({31'h0, busy}, 32'h1);
        rst <= 1;
        repeat (2) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
        rst <= 0;
        repeat (1000) @(posedge clk);
        stop_test();
    end
endmodule
